// ### hw/ssec_supervisor.sv
// ssec_supervisor: supply reset gating, watchdog, serial eeprom port
// assumes: sck only toggles while select_kick_input_n is low; pins async
// Function
// - reset output asserted from about one volt
// - release after trip held for release delay
// - no serial commands while reset asserted
// - brown-out asserts reset, aborts serial transaction
// - after brown-out, wait release delay again
// - missing select falling edge fires watchdog reset
// - no bus activity for timeout asserts reset
// - period selector bits survive power loss
// - raise trip: high voltage, latch, 00h to 01h
// - native trip: same sequence, 00h to 03h
// - 8-bit opcode shifted on rising sck, select low
// - msb first, first bit after select falls
// - serial output changes on falling sck
// - serial logic static, sck may pause
// - write needs latch; set and clear opcodes
// - latch cleared at power-up and write end
// - status readable any time, even while writing
// - status: 000, period selectors, area selector
// - fixed opcode encodings for six commands
// - selector 00/01/10 give 1.4s/600ms/200ms
// - area selector protects regions from writes
`timescale 1ns/1ps
`include "ssec_regs.svh"
module ssec_supervisor
    import ssec_pkg::*;
#(
    parameter int ADDR_W    = 10,
    parameter int POR_CYC   = `SSEC_MS_TO_CYC(`SSEC_RELEASE_MS),
    parameter int WR_CYC    = `SSEC_MS_TO_CYC(`SSEC_WRITE_MS),
    parameter int CYC_SEL00 = `SSEC_MS_TO_CYC(`SSEC_WD_SEL00_MS),
    parameter int CYC_SEL01 = `SSEC_MS_TO_CYC(`SSEC_WD_SEL01_MS),
    parameter int CYC_SEL10 = `SSEC_MS_TO_CYC(`SSEC_WD_SEL10_MS)
)
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic sck,
    input  wire logic select_kick_input_n,
    input  wire logic si,
    input  wire logic write_guard_n,
    input  wire logic write_guard_hv,
    input  wire logic vcc_above_1v,
    input  wire logic vcc_above_trip,
    output logic      so_o,
    output logic      so_oe_n,
    output logic      reset_pin_o,
    output logic      reset_pin_oe_n,
    output logic      trip_raise_o,
    output logic      trip_native_o
);
    localparam int PAGE = 16;  // bytes per page write

    // clk domain state read by the sck domain
    logic             port_block_reg;   // serial port held off
    logic       [4:0] stat_reg;         // nonvolatile period and area bits
    ssec_byte_t       mem [2**ADDR_W];  // nonvolatile array

    // sck domain frame capture
    logic             frm_clr;          // async frame clear
    logic             armed_reg;        // next edge starts a frame
    logic             frame_tog_reg;    // toggles once per frame
    logic       [2:0] bit_cnt_reg;      // bits of current byte
    logic       [1:0] byte_cnt_reg;     // bytes done, saturates at 3
    logic       [3:0] data_idx_reg;     // data bytes, wraps in page
    ssec_byte_t       rx_reg;           // input shifter
    ssec_byte_t       op_reg;           // captured opcode
    ssec_byte_t       addr_hi_reg;      // address high byte
    ssec_byte_t       addr_lo_reg;      // address low byte
    ssec_byte_t       stat_data_reg;    // status write data
    ssec_byte_t       page_buf [PAGE];  // write data per slot
    logic  [PAGE-1:0] mask_reg;         // slots written this frame
    logic [ADDR_W-1:0] rd_ptr_reg;      // sequential read address

    // frame state combinational terms
    logic       [2:0] bit_base;         // bit count seen at this edge
    logic       [1:0] byte_base;        // byte count seen at this edge
    logic             byte_done;        // eighth bit arrives now
    ssec_byte_t       rx_next;          // shifter after this bit
    logic       [3:0] slot;             // page slot of this data byte
    ssec_byte_t       tx_byte;          // byte being shifted out

    // a frame ends on deselect; reset also forces every frame dead
    assign frm_clr = select_kick_input_n | port_block_reg;

    // first rising edge after select falls opens a frame
    always_ff @(posedge sck or posedge frm_clr)
    begin
        if (frm_clr)
            armed_reg <= 1'b1;
        else
            armed_reg <= 1'b0;
    end

    assign bit_base  = armed_reg ? 3'h0 : bit_cnt_reg;
    assign byte_base = armed_reg ? 2'h0 : byte_cnt_reg;
    assign byte_done = bit_base == 3'h7;
    assign rx_next   = {rx_reg[6:0], si};
    assign slot      = addr_lo_reg[3:0] + data_idx_reg;

    // counters survive deselect so the clk side can judge the frame
    always_ff @(posedge sck or posedge port_block_reg)
    begin
        if (port_block_reg)
        begin
            bit_cnt_reg   <= 3'h0;
            byte_cnt_reg  <= 2'h0;
            frame_tog_reg <= 1'b0;
        end
        else
        begin
            bit_cnt_reg <= bit_base + 3'h1;
            if (armed_reg)
                frame_tog_reg <= ~frame_tog_reg;
            if (byte_done && byte_base != 2'h3)
                byte_cnt_reg <= byte_base + 2'h1;
            else
                byte_cnt_reg <= byte_base;
        end
    end

    // shifter and field capture on rising sck
    always_ff @(posedge sck)
    begin
        rx_reg <= rx_next;
        if (byte_done)
        begin
            case (byte_base)
                2'h0:
                    op_reg <= rx_next;
                2'h1:
                begin
                    addr_hi_reg   <= rx_next;
                    stat_data_reg <= rx_next;
                end
                2'h2:
                    addr_lo_reg <= rx_next;
                default:
                    page_buf[slot] <= rx_next;
            endcase
        end
    end

    // slot mask and read pointer, restarted by each address
    always_ff @(posedge sck)
    begin
        if (byte_done && byte_base == 2'h2)
        begin
            mask_reg     <= '0;
            data_idx_reg <= 4'h0;
            rd_ptr_reg   <= ADDR_W'({addr_hi_reg, rx_next});
        end
        else if (byte_done && byte_base == 2'h3)
        begin
            mask_reg[slot] <= 1'b1;
            data_idx_reg   <= data_idx_reg + 4'h1;
            rd_ptr_reg     <= rd_ptr_reg + ADDR_W'(1);
        end
    end

    // outgoing byte: status works even mid write cycle
    always_comb
    begin
        if (op_reg == `SSEC_OP_STAT_RD && byte_base != 2'h0)
            tx_byte = {3'h0, stat_reg};
        else if (op_reg == `SSEC_OP_MEM_RD && byte_base == 2'h3)
            tx_byte = mem[rd_ptr_reg];
        else
            tx_byte = 8'h00;
    end

    // serial output moves on falling sck, released when deselected
    always_ff @(negedge sck or posedge frm_clr)
    begin
        if (frm_clr)
        begin
            so_oe_n <= 1'b1;
            so_o    <= 1'b0;
        end
        else
        begin
            so_oe_n <= 1'b0;
            so_o    <= tx_byte[3'h7 - bit_base];
        end
    end

    // pin synchronisers on clk
    logic cs_s;      // select, synced
    logic trip_s;    // supply above trip, synced
    logic v1v_s;     // supply above one volt, synced
    logic guard_s;   // write guard high, synced
    logic hv_s;      // guard at programming voltage, synced

    ssec_sync #(
        .W       (5),
        .RST_VAL (5'h10)
    ) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({select_kick_input_n, vcc_above_trip, vcc_above_1v,
                write_guard_n, write_guard_hv}),
        .q    ({cs_s, trip_s, v1v_s, guard_s, hv_s})
    );

    logic              cs_prev_reg;   // last synced select
    logic              cs_rise;       // frame ended
    logic              cs_fall;       // watchdog kick
    logic              wd_expire;     // watchdog timeout pulse
    logic       [31:0] por_cnt_reg;   // cycles of good supply
    logic              rst_act_reg;   // reset output active
    logic              rst_act_next;  // next reset state
    logic              abort_reg;     // frame hit by reset
    logic              tog_seen_reg;  // last frame toggle handled
    logic              frame_ok;      // complete frame ended cleanly
    logic              wel_reg;       // write enable latch
    ssec_wstate_e      ws_reg;        // write cycle state
    logic       [31:0] wcyc_reg;      // write cycle timer
    logic              wr_done;       // write cycle ends now
    logic              start_stat;    // status write accepted
    logic              start_mem;     // memory write accepted
    logic       [15:0] full_addr;     // captured 16-bit address
    logic              trip_cmd;      // high voltage trip sequence
    logic   [PAGE-1:0] slot_ok;       // slot may be written

    assign cs_rise   = cs_s & ~cs_prev_reg;
    assign cs_fall   = ~cs_s & cs_prev_reg;
    assign full_addr = {addr_hi_reg, addr_lo_reg};

    // edge history of select
    always_ff @(posedge clk)
    begin
        if (!rstn)
            cs_prev_reg <= 1'b1;
        else
            cs_prev_reg <= cs_s;
    end

    ssec_wdog #(
        .CYC_SEL00 (CYC_SEL00),
        .CYC_SEL01 (CYC_SEL01),
        .CYC_SEL10 (CYC_SEL10)
    ) u_wdog (
        .clk    (clk),
        .rstn   (rstn),
        .kick   (cs_fall),
        .run    (~rst_act_reg),
        .sel    (stat_reg[`SSEC_ST_PSEL_HI:`SSEC_ST_PSEL_LO]),
        .expire (wd_expire)
    );

    // reset stays until supply good for the whole release delay
    always_comb
    begin
        rst_act_next = por_cnt_reg != 32'(POR_CYC);
        if (!trip_s || wd_expire)
            rst_act_next = 1'b1;
    end

    // release counter restarts on brown-out or watchdog fault
    always_ff @(posedge clk)
    begin
        if (!rstn)
            por_cnt_reg <= 32'h0;
        else if (!trip_s || wd_expire)
            por_cnt_reg <= 32'h0;
        else if (por_cnt_reg != 32'(POR_CYC))
            por_cnt_reg <= por_cnt_reg + 32'h1;
    end

    // open-drain reset pin, driven low only above one volt
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rst_act_reg    <= 1'b1;
            port_block_reg <= 1'b1;
            reset_pin_o    <= 1'b0;
            reset_pin_oe_n <= 1'b1;
        end
        else
        begin
            rst_act_reg    <= rst_act_next;
            port_block_reg <= rst_act_next;
            reset_pin_o    <= 1'b0;
            reset_pin_oe_n <= ~(rst_act_next & v1v_s);
        end
    end

    // frame judgement: aborted frames and empty frames do nothing
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            abort_reg    <= 1'b0;
            tog_seen_reg <= 1'b0;
        end
        else
        begin
            if (cs_s)
                abort_reg <= 1'b0;
            else if (port_block_reg)
                abort_reg <= 1'b1;
            if (port_block_reg)
                tog_seen_reg <= 1'b0;
            else if (cs_rise)
                tog_seen_reg <= frame_tog_reg;
        end
    end

    assign frame_ok = cs_rise && !abort_reg && !port_block_reg
                      && frame_tog_reg != tog_seen_reg
                      && bit_cnt_reg == 3'h0 && ws_reg == ws_idle;

    // trip sequence: the data byte at the target slot must be the trip value
    assign trip_cmd   = hv_s && page_buf[full_addr[3:0]] == `SSEC_TRIP_DATA
                        && (full_addr == `SSEC_TRIP_RAISE_ADDR
                        || full_addr == `SSEC_TRIP_NATIVE_ADDR);
    assign start_stat = frame_ok && op_reg == `SSEC_OP_STAT_WR
                        && byte_cnt_reg >= 2'h2 && wel_reg && guard_s;
    assign start_mem  = frame_ok && op_reg == `SSEC_OP_MEM_WR
                        && byte_cnt_reg == 2'h3 && mask_reg != '0
                        && wel_reg && guard_s;
    assign wr_done    = ws_reg == ws_busy && wcyc_reg == 32'(WR_CYC) - 32'h1;

    // protected region test for one address
    function automatic logic area_hit(input logic [ADDR_W-1:0] a,
                                      input logic [2:0]        sel);
        logic [1:0] quarter;
        logic       first_pg;
        logic       last_pg;
        begin
            quarter  = a[ADDR_W-1 -: 2];
            first_pg = a[ADDR_W-1:4] == '0;
            last_pg  = &a[ADDR_W-1:4];
            case (sel)
                3'h0:    area_hit = 1'b0;
                3'h5:    area_hit = ~a[ADDR_W-1];
                3'h6:    area_hit = first_pg;
                3'h7:    area_hit = last_pg;
                default: area_hit = {1'b0, quarter} == sel - 3'h1;
            endcase
        end
    endfunction

    // per slot write permission
    for (genvar i = 0; i < PAGE; i++)
    begin : g_slot
        assign slot_ok[i] = mask_reg[i] && !area_hit(
            {full_addr[ADDR_W-1:4], 4'(i)}, stat_reg[2:0]);
    end

    // array commit; protected bytes stay as they were
    // page base from the start address, the read pointer moves per byte
    always_ff @(posedge clk)
    begin
        if (start_mem)
        begin
            for (int i = 0; i < PAGE; i++)
            begin
                if (slot_ok[i])
                    mem[{full_addr[ADDR_W-1:4], 4'(i)}] <= page_buf[i];
            end
        end
    end

    // nonvolatile status: only rstn (first power) resets it; a status write loads it
    always_ff @(posedge clk)
    begin
        if (!rstn)
            stat_reg <= `SSEC_STAT_RST;
        else if (start_stat)
            stat_reg <= stat_data_reg[4:0];
    end

    // write cycle timer
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ws_reg   <= ws_idle;
            wcyc_reg <= 32'h0;
        end
        else
        begin
            case (ws_reg)
                ws_idle:
                begin
                    wcyc_reg <= 32'h0;
                    if (start_stat || start_mem)
                        ws_reg <= ws_busy;
                end
                ws_busy:
                begin
                    wcyc_reg <= wcyc_reg + 32'h1;
                    if (wr_done)
                        ws_reg <= ws_idle;
                end
                default:
                    ws_reg <= ws_idle;
            endcase
        end
    end

    // write enable latch
    always_ff @(posedge clk)
    begin
        if (!rstn || !v1v_s)
            wel_reg <= 1'b0;
        else if (wr_done)
            wel_reg <= 1'b0;
        else if (frame_ok && byte_cnt_reg != 2'h0)
        begin
            if (op_reg == `SSEC_OP_LATCH_SET)
                wel_reg <= 1'b1;
            else if (op_reg == `SSEC_OP_LATCH_CLR)
                wel_reg <= 1'b0;
        end
    end

    // trip programming strobes last the write cycle
    always_ff @(posedge clk)
    begin
        if (!rstn || wr_done)
        begin
            trip_raise_o  <= 1'b0;
            trip_native_o <= 1'b0;
        end
        else if (start_mem && trip_cmd)
        begin
            trip_raise_o  <= full_addr == `SSEC_TRIP_RAISE_ADDR;
            trip_native_o <= full_addr == `SSEC_TRIP_NATIVE_ADDR;
        end
    end

    // helper: consecutive cycles of good supply
    logic [31:0] ok_run_reg;
    always_ff @(posedge clk)
    begin
        if (!rstn || !trip_s)
            ok_run_reg <= 32'h0;
        else if (ok_run_reg != 32'hffffffff)
            ok_run_reg <= ok_run_reg + 32'h1;
    end

    a_release_delay: assert property (@(posedge clk) disable iff (!rstn)
        $fell(rst_act_reg) |-> ok_run_reg >= 32'(POR_CYC))
        else $error("reset released before supply good long enough");
    a_brownout_reset: assert property (@(posedge clk) disable iff (!rstn)
        (!trip_s && v1v_s) |=> (rst_act_reg && !reset_pin_oe_n))
        else $error("brown-out did not assert reset");
    a_port_blocked: assert property (@(posedge clk) disable iff (!rstn)
        $rose(wel_reg) |-> !$past(port_block_reg))
        else $error("latch set while port blocked");
    a_wdog_reset: assert property (@(posedge clk) disable iff (!rstn)
        wd_expire |=> (rst_act_reg ##1 port_block_reg))
        else $error("watchdog timeout did not assert reset");
    a_latch_needed: assert property (@(posedge clk) disable iff (!rstn)
        (start_stat || start_mem) |-> (wel_reg && guard_s))
        else $error("write started without latch");
    a_latch_done: assert property (@(posedge clk) disable iff (!rstn)
        wr_done |=> (!wel_reg && ws_reg == ws_idle))
        else $error("latch not cleared at write end");
    a_status_load: assert property (@(posedge clk) disable iff (!rstn)
        start_stat |=> stat_reg == 5'($past(stat_data_reg)))
        else $error("status write lost");
    a_trip_raise: assert property (@(posedge clk) disable iff (!rstn)
        (start_mem && trip_cmd && full_addr == `SSEC_TRIP_RAISE_ADDR)
        |=> (trip_raise_o && !trip_native_o))
        else $error("raise sequence did not start programming");
    a_latch_set_cmd_sets: assert property (@(posedge clk) disable iff (!rstn)
        (frame_ok && byte_cnt_reg != 2'h0 && op_reg == `SSEC_OP_LATCH_SET
        && v1v_s) |=> wel_reg)
        else $error("latch set opcode ignored");
endmodule

// ### hw/ssec_regs.svh
// ssec_regs.svh: opcodes, status fields, addresses and timing counts
// assumes: included by bare name; definitions only, no logic
`ifndef SSEC_REGS_SVH
`define SSEC_REGS_SVH

`define SSEC_CLK_KHZ          40000
`define SSEC_MS_TO_CYC(ms)    ((ms) * `SSEC_CLK_KHZ)

`define SSEC_OP_LATCH_SET     8'h06
`define SSEC_OP_LATCH_CLR     8'h04
`define SSEC_OP_STAT_WR       8'h01
`define SSEC_OP_STAT_RD       8'h05
`define SSEC_OP_MEM_WR        8'h02
`define SSEC_OP_MEM_RD        8'h03

`define SSEC_ST_PSEL_HI       4
`define SSEC_ST_PSEL_LO       3
`define SSEC_ST_AREA_MSB      2
`define SSEC_STAT_RST         5'h00

`define SSEC_TRIP_RAISE_ADDR  16'h0001
`define SSEC_TRIP_NATIVE_ADDR 16'h0003
`define SSEC_TRIP_DATA        8'h00

`define SSEC_RELEASE_MS       200
`define SSEC_WD_SEL00_MS      1400
`define SSEC_WD_SEL01_MS      600
`define SSEC_WD_SEL10_MS      200
`define SSEC_WRITE_MS         5

`endif

// ### hw/ssec_pkg.sv
// ssec_pkg: shared types of the supervisor eeprom controller
// assumes: compiled before every module of the block
package ssec_pkg;
    typedef logic [7:0] ssec_byte_t;              // one serial byte
    typedef enum {ws_idle, ws_busy} ssec_wstate_e; // nonvolatile write cycle
endpackage

// ### hw/ssec_sync.sv
// ssec_sync: two flip-flop level synchroniser, one per bit
// assumes: d comes from pins outside the clk domain
`timescale 1ns/1ps
module ssec_sync
    import ssec_pkg::*;
#(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;  // first stage, read only by q

    // two stages, synchronous reset to the idle level
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            meta_reg <= RST_VAL;
            q        <= RST_VAL;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// ### hw/ssec_wdog.sv
// ssec_wdog: watchdog counter restarted by kick pulses
// assumes: kick is a one-cycle pulse on clk; sel 11 turns it off
`timescale 1ns/1ps
`include "ssec_regs.svh"
module ssec_wdog
    import ssec_pkg::*;
#(
    parameter int CYC_SEL00 = `SSEC_MS_TO_CYC(`SSEC_WD_SEL00_MS),
    parameter int CYC_SEL01 = `SSEC_MS_TO_CYC(`SSEC_WD_SEL01_MS),
    parameter int CYC_SEL10 = `SSEC_MS_TO_CYC(`SSEC_WD_SEL10_MS)
)
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       kick,
    input  wire logic       run,
    input  wire logic [1:0] sel,
    output logic            expire
);
    logic [31:0] cnt_reg;  // cycles since last kick
    logic [31:0] limit;    // selected period in cycles

    // period lookup from the two selector bits
    always_comb
    begin
        case (sel)
            2'h0:    limit = 32'(CYC_SEL00);
            2'h1:    limit = 32'(CYC_SEL01);
            default: limit = 32'(CYC_SEL10);
        endcase
    end

    // count up, restart on kick, pulse on timeout
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cnt_reg <= 32'h0;
            expire  <= 1'b0;
        end
        else if (!run || kick || sel == 2'h3)
        begin
            cnt_reg <= 32'h0;
            expire  <= 1'b0;
        end
        else if (cnt_reg >= limit - 32'h1)
        begin
            cnt_reg <= 32'h0;
            expire  <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 32'h1;
            expire  <= 1'b0;
        end
    end
endmodule

// ### verif/ssec_host_model.sv
// ssec_host_model: spi master standing in for the microcontroller
// assumes: mode 0; sck idles low and runs only inside frames
`timescale 1ns/1ps
module ssec_host_model
(
    output logic       sck,
    output logic       cs_n,
    output logic       si,
    input  wire logic  so,
    output logic [7:0] rd_byte,
    output logic       rd_done
);
    // idle bus at time zero
    initial
    begin
        sck = 0;
        cs_n = 1;
        si = 0;
        rd_done = 0;
    end
    // n bits of v, 48 ns per bit; slow stops sck for a while mid-frame
    task automatic frame(input logic [31:0] v, input int n, input bit rd, input bit slow);
        #3 cs_n = 0;
        for (int i = n - 1; i >= 0; i--)
        begin
            si = v[i];
            #24 sck = 1;
            rd_byte = {rd_byte[6:0], so};
            #24 sck = 0;
            if (slow && i == n / 2)
                #500;
        end
        #48 cs_n = 1;
        si = ~si;                       // released line shows no stale level
        if (rd)
            rd_done = 1;
        #1 rd_done = 0;
        #200;                           // gap before the next frame
    endtask
endmodule

// ### verif/ssec_supervisor_tb_top.sv
// ssec_supervisor_tb_top: self-checking bench of the supervisor
// assumes: host model drives serial pins, bench drives supply pins
`timescale 1ns/1ps
module ssec_supervisor_tb_top
    import ssec_pkg::*;
;
    localparam int POR = 50;   // short release delay
    localparam int WR  = 20;   // short write cycle
    localparam int S10 = 300;  // short watchdog period, selector 10
    logic       clk = 0, rstn = 0, v1 = 0, vt = 0, hv = 0, wg = 1;
    logic       sck, cs_n, si, so, so_oe_n, rp_o, rp_oe_n, t_up, t_nat, rd_done;
    ssec_byte_t rd_byte, d;
    ssec_byte_t exp_q[$];      // expected read bytes, oldest first
    int         num_errors = 0, tests_run = 0, n;
    wire  [2:0] pins = {t_nat, t_up, rp_oe_n};

    ssec_supervisor #(.POR_CYC(POR), .WR_CYC(WR), .CYC_SEL00(600), .CYC_SEL01(400),
        .CYC_SEL10(S10)) dut (.clk(clk), .rstn(rstn), .sck(sck),
        .select_kick_input_n(cs_n), .si(si), .write_guard_n(wg), .write_guard_hv(hv),
        .vcc_above_1v(v1), .vcc_above_trip(vt), .so_o(so), .so_oe_n(so_oe_n),
        .reset_pin_o(rp_o), .reset_pin_oe_n(rp_oe_n), .trip_raise_o(t_up),
        .trip_native_o(t_nat));
    ssec_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .rd_byte(rd_byte),
        .rd_done(rd_done));

    always #12.5 clk = ~clk;

    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // wait for pin s at level l, n counts clk cycles
    task automatic wait_pin(input int s, input logic l, input int lim);
        for (n = 0; pins[s] !== l; n++)
        begin
            if (n == lim)
            begin
                check("wait_bound", 8'h00, 8'h01);
                summarize();
            end
            @(posedge clk);
            #1;
        end
    endtask
    // read frame: note the expected byte first
    task automatic rd(input logic [31:0] v, input int nb, input ssec_byte_t e, input bit s);
        exp_q.push_back(e);
        host.frame(v, nb, 1'b1, s);
    endtask
    // command frame, then let a write cycle finish
    task automatic wr(input logic [31:0] v, input int nb);
        host.frame(v, nb, 1'b0, 1'b0);
        repeat (WR + 10) @(posedge clk);
    endtask

    // compare each read byte with the oldest note
    always @(posedge rd_done)
    begin
        check("read_byte", exp_q.pop_front(), rd_byte);
    end

    initial
    begin
        d = 8'($urandom(32'hc519));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        v1 <= 1'b1;
        vt <= 1'b1;
        wait_pin(0, 1'b0, 8);
        wait_pin(0, 1'b1, POR + 20);
        check("por_len", 8'h01, {7'h0, n inside {[POR - 2:POR + 6]}});
        repeat (4) @(posedge clk);
        rd(32'h0500, 16, 8'h00, 1'b1);
        wr(32'h06, 8);
        host.frame({8'h02, 16'h0150, d}, 32, 1'b0, 1'b0);
        rd(32'h0500, 16, 8'h00, 1'b0);
        repeat (WR) @(posedge clk);
        rd({8'h03, 16'h0150, 8'h00}, 32, d, 1'b0);
        wr(32'h0112, 16);
        rd(32'h0500, 16, 8'h00, 1'b0);
        wr(32'h06, 8);
        wr(32'h0112, 16);
        wr(32'h06, 8);
        wr(32'h04, 8);
        wr(32'h0100, 16);
        wg <= 1'b0;
        wr(32'h06, 8);
        wr(32'h0100, 16);
        wg <= 1'b1;
        rd(32'h0500, 16, 8'h12, 1'b0);
        wr(32'h06, 8);
        wr({8'h02, 16'h0150, ~d}, 32);
        rd({8'h03, 16'h0150, 8'h00}, 32, d, 1'b0);
        @(posedge clk);
        hv <= 1'b1;
        wr(32'h06, 8);
        host.frame({8'h02, 16'h0003, 8'h00}, 32, 1'b0, 1'b0);
        wait_pin(2, 1'b1, 10);
        wait_pin(2, 1'b0, WR + 4);
        wr(32'h06, 8);
        host.frame({8'h02, 16'h0001, 8'h00}, 32, 1'b0, 1'b0);
        wait_pin(1, 1'b1, 10);
        wait_pin(1, 1'b0, WR + 4);
        @(posedge clk);
        hv <= 1'b0;
        rd({8'h03, 16'h0001, 8'h00}, 32, 8'h00, 1'b0);
        @(posedge clk);
        vt <= 1'b0;
        wait_pin(0, 1'b0, 6);
        wr(32'h06, 8);
        wr(32'h0100, 16);
        @(posedge clk);
        vt <= 1'b1;
        wait_pin(0, 1'b1, POR + 10);
        check("bo_len", 8'h01, {7'h0, n inside {[POR - 2:POR + 6]}});
        repeat (4) @(posedge clk);
        rd(32'h0500, 16, 8'h12, 1'b0);
        repeat (3)
        begin
            repeat (S10 - 60) @(posedge clk);
            host.frame(32'h0, 0, 1'b0, 1'b0);
        end
        check("kicked", 8'h01, {7'h0, rp_oe_n});
        check("so_idle", 8'h01, {7'h0, so_oe_n});
        check("rst_level", 8'h00, {7'h0, rp_o});
        wait_pin(0, 1'b0, S10 + 10);
        check("wd_len", 8'h01, {7'h0, n inside {[S10 - 30:S10 + 4]}});
        summarize();
    end
endmodule
